// ==== hdl/prec_pkg.sv ====
package prec_pkg;
  // number of gate drive channels
  localparam int unsigned NUM_CH = 6;
  // timer clock rate and the host's least gap between frames
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned XFER_GAP_NS = 1600;
  // cycles in the host's least gap between frames, for reference
  localparam int unsigned XFER_GAP_CYC = (XFER_GAP_NS * CLK_MHZ + 999) / 1000;
  // reset values
  localparam logic [5:0] GATE_RST = 6'h00;
  localparam logic [5:0] FAULT_RST = 6'h00;
  localparam logic [5:0] RETRY_RST = 6'h00;
  localparam logic [15:0] RETRY_CNT_RST = 16'h0000;
  // retry period in timer cycles; kept small and fixed for this wrapper
  localparam logic [15:0] RETRY_PERIOD = 16'h0FA0;
  // sequencer states, gray along power up
  typedef enum logic [1:0] {
    PREC_OFF_S = 2'b00,
    PREC_RST_S = 2'b01,
    PREC_RUN_S = 2'b11,
    PREC_DIS_S = 2'b10
  } prec_state_t;
endpackage : prec_pkg

// ==== hdl/prec_sync_if.sv ====
`timescale 1ns/1ps
// synchronised control levels passed from the synchroniser to the sequencer
interface prec_sync_if;
  logic reset_n; // synchronised external reset, active low
  logic enable_n; // synchronised global enable, active low
  modport src (output reset_n, output enable_n);
  modport dst (input reset_n, input enable_n);
endinterface : prec_sync_if

// ==== hdl/prec_sync.sv ====
`timescale 1ns/1ps
// two flop synchroniser for the reset and enable pins
module prec_sync (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic device_reset_in_n,
  input wire logic global_enable_in_n,
  prec_sync_if.src sync_out
);
  logic [1:0] meta_ff; // first stage, read only by second stage
  logic [1:0] stab_ff; // second stage
  logic [1:0] nxt_meta;
  logic [1:0] nxt_stab;

  // next values of both stages
  always_comb begin
    nxt_meta = {global_enable_in_n, device_reset_in_n};
    nxt_stab = meta_ff;
  end

  // reset holds device in reset and disabled
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_ff <= 2'h2;
      stab_ff <= 2'h2;
    end else begin
      meta_ff <= nxt_meta;
      stab_ff <= nxt_stab;
    end
  end

  assign sync_out.reset_n = stab_ff[0];
  assign sync_out.enable_n = stab_ff[1];
endmodule : prec_sync

// ==== hdl/prec_seq.sv ====
`timescale 1ns/1ps
// How it works
// - gates low while supply below threshold
// - power on loads defaults, clears status, flag off
// - above threshold, initialise and accept commands
// - power down: flag off, gates held low
// - external reset: gates, timer, port, flag off
// - reset restores defaults; release re-enables port, flag
// - enable high: gates, diagnostics off, retry reset
// - disabled: port alive, faults and settings kept
// - enable low re-enables fault-shut outputs
module prec_seq (
  input wire logic ref_clk_in,
  input wire logic rst_b_in, // power-on reset from supply monitor
  input wire logic device_reset_in_n, // external reset pin
  input wire logic global_enable_in_n, // global enable pin
  input wire logic cmd_valid_in, // decoded serial command strobe
  input wire logic [5:0] cmd_gate_in, // gate bits of the command
  input wire logic [5:0] cmd_retry_in, // retry mode bits of the command
  input wire logic [5:0] fault_det_in, // per-channel fault pulses
  output logic [5:0] gate_drive_out, // gate drives
  output logic fault_flag_oe_out, // open-drain flag drives low when high
  output logic fault_flag_out_n, // flag level, low when a fault shows
  output logic port_enable_out, // serial port may accept frames
  output logic timer_run_out, // timer clock gated on
  output logic diag_enable_out, // diagnostics allowed
  output logic [5:0] fault_latched_out // latched fault status
);
  prec_sync_if sync_bus ();
  prec_pkg::prec_state_t state_ff, nxt_state;
  logic [5:0] gate_ff, nxt_gate; // programmed gate requests
  logic [5:0] retry_ff, nxt_retry; // auto-retry selects
  logic [5:0] fault_ff, nxt_fault; // latched faults
  logic [5:0] shut_ff, nxt_shut; // channels shut off by a fault
  logic [15:0] rcnt_ff, nxt_rcnt; // retry timer
  logic [5:0] drv_ff, nxt_drv;
  logic flag_oe_ff, nxt_flag_oe;
  logic flag_n_ff, nxt_flag_n; // flag pin level kept in its own flop
  logic port_ff, nxt_port;
  logic tmr_ff, nxt_tmr;
  logic diag_ff, nxt_diag;
  logic run_ok; // in run with enable low

  // synchronise external pins to the timer clock
  prec_sync u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .device_reset_in_n(device_reset_in_n),
    .global_enable_in_n(global_enable_in_n),
    .sync_out(sync_bus.src)
  );

  // sequencer state
  always_comb begin
    case (state_ff)
      prec_pkg::PREC_OFF_S: nxt_state = prec_pkg::PREC_RST_S;
      prec_pkg::PREC_RST_S: begin
        // stay until external reset released
        nxt_state = sync_bus.reset_n ? prec_pkg::PREC_RUN_S : prec_pkg::PREC_RST_S;
      end
      prec_pkg::PREC_RUN_S: begin
        if (!sync_bus.reset_n) begin
          nxt_state = prec_pkg::PREC_RST_S;
        end else if (sync_bus.enable_n) begin
          nxt_state = prec_pkg::PREC_DIS_S;
        end else begin
          nxt_state = prec_pkg::PREC_RUN_S;
        end
      end
      prec_pkg::PREC_DIS_S: begin
        if (!sync_bus.reset_n) begin
          nxt_state = prec_pkg::PREC_RST_S;
        end else if (!sync_bus.enable_n) begin
          nxt_state = prec_pkg::PREC_RUN_S;
        end else begin
          nxt_state = prec_pkg::PREC_DIS_S;
        end
      end
      default: nxt_state = prec_pkg::PREC_OFF_S;
    endcase
  end

  assign run_ok = (state_ff == prec_pkg::PREC_RUN_S) && !(!sync_bus.reset_n)
    && !sync_bus.enable_n;

  // registers, faults and retry timer
  always_comb begin
    nxt_gate = gate_ff;
    nxt_retry = retry_ff;
    nxt_fault = fault_ff;
    nxt_shut = shut_ff;
    nxt_rcnt = rcnt_ff;
    if (state_ff == prec_pkg::PREC_RST_S || state_ff == prec_pkg::PREC_OFF_S) begin
      // defaults and cleared status
      nxt_gate = prec_pkg::GATE_RST;
      nxt_retry = prec_pkg::RETRY_RST;
      nxt_fault = prec_pkg::FAULT_RST;
      nxt_shut = prec_pkg::FAULT_RST;
      nxt_rcnt = prec_pkg::RETRY_CNT_RST;
    end else begin
      // port stays alive while disabled
      if (cmd_valid_in) begin
        nxt_gate = cmd_gate_in;
        nxt_retry = cmd_retry_in;
      end
      if (state_ff == prec_pkg::PREC_DIS_S) begin
        nxt_rcnt = prec_pkg::RETRY_CNT_RST;
        nxt_shut = prec_pkg::FAULT_RST;
      end else begin
        // set wins over the retry release
        if (rcnt_ff == prec_pkg::RETRY_PERIOD) begin
          nxt_rcnt = prec_pkg::RETRY_CNT_RST;
          nxt_shut = shut_ff & ~retry_ff;
        end else if (|(shut_ff & retry_ff)) begin
          nxt_rcnt = rcnt_ff + 16'h0001;
        end
        nxt_fault = fault_ff | fault_det_in;
        nxt_shut = nxt_shut | fault_det_in;
      end
    end
  end

  // output gating
  always_comb begin
    nxt_drv = run_ok ? (gate_ff & ~shut_ff) : prec_pkg::GATE_RST;
    nxt_flag_oe = run_ok && (|fault_ff);
    nxt_flag_n = ~nxt_flag_oe;
    nxt_port = (state_ff != prec_pkg::PREC_RST_S) && (state_ff != prec_pkg::PREC_OFF_S)
      && sync_bus.reset_n;
    nxt_tmr = nxt_port;
    nxt_diag = run_ok;
  end

  // power-on reset clears all state
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= prec_pkg::PREC_OFF_S;
      gate_ff <= prec_pkg::GATE_RST;
      retry_ff <= prec_pkg::RETRY_RST;
      fault_ff <= prec_pkg::FAULT_RST;
      shut_ff <= prec_pkg::FAULT_RST;
      rcnt_ff <= prec_pkg::RETRY_CNT_RST;
      drv_ff <= prec_pkg::GATE_RST;
      flag_oe_ff <= 1'b0;
      flag_n_ff <= 1'b1;
      port_ff <= 1'b0;
      tmr_ff <= 1'b0;
      diag_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      gate_ff <= nxt_gate;
      retry_ff <= nxt_retry;
      fault_ff <= nxt_fault;
      shut_ff <= nxt_shut;
      rcnt_ff <= nxt_rcnt;
      drv_ff <= nxt_drv;
      flag_oe_ff <= nxt_flag_oe;
      flag_n_ff <= nxt_flag_n;
      port_ff <= nxt_port;
      tmr_ff <= nxt_tmr;
      diag_ff <= nxt_diag;
    end
  end

  assign gate_drive_out = drv_ff;
  assign fault_flag_oe_out = flag_oe_ff;
  assign fault_flag_out_n = flag_n_ff;
  assign port_enable_out = port_ff;
  assign timer_run_out = tmr_ff;
  assign diag_enable_out = diag_ff;
  assign fault_latched_out = fault_ff;

  // gates never drive while disabled
  a_gate_off_dis: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_DIS_S |=> gate_drive_out == 6'h00)
    else $error("gates driven while disabled");
  // reset clears faults next cycle
  a_rst_clears: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_RST_S |=> fault_latched_out == 6'h00)
    else $error("faults not cleared in reset");
  // reset pin low reaches reset state within three cycles
  a_pin_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $fell(device_reset_in_n) ##1 !device_reset_in_n[*2]
      |=> state_ff == prec_pkg::PREC_RST_S)
    else $error("external reset not taken");
  // flag and port off during reset
  a_rst_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_RST_S |=> !fault_flag_oe_out && !port_enable_out)
    else $error("flag or port active in reset");
  // latched faults kept while disabled
  a_keep_fault: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_DIS_S && nxt_state == prec_pkg::PREC_DIS_S
      |=> fault_latched_out == $past(fault_latched_out))
    else $error("fault data lost while disabled");
  // retry timer reset while disabled
  a_retry_rst: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_DIS_S |=> rcnt_ff == 16'h0000)
    else $error("retry timer not reset");
  // re-enable clears fault shutdowns
  a_reenable: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_DIS_S ##1 state_ff == prec_pkg::PREC_RUN_S
      |-> shut_ff == 6'h00)
    else $error("shut channels not released");
  // gates forced low while in external reset
  a_gate_off_rst: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_RST_S |=> gate_drive_out == 6'h00)
    else $error("gates driven in reset");
  // timer clock stopped while in external reset
  a_timer_off_rst: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_RST_S |=> !timer_run_out)
    else $error("timer running in reset");
  // diagnostics off while disabled
  a_diag_off_dis: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_DIS_S |=> !diag_enable_out)
    else $error("diagnostics on while disabled");
  // serial port stays alive while disabled
  a_port_dis: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_DIS_S && sync_bus.reset_n |=> port_enable_out)
    else $error("port off while disabled");
  // leaving power-on reset goes to reset state next cycle
  a_power_up: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == prec_pkg::PREC_OFF_S |=> state_ff == prec_pkg::PREC_RST_S)
    else $error("power up sequence broken");
endmodule : prec_seq

// ==== verif/prec_host_model.sv ====
`timescale 1ns/1ps
// host side: drives the reset and enable pins and decoded commands
module prec_host_model (
  input wire logic ref_clk_in,
  output logic device_reset_in_n,
  output logic global_enable_in_n,
  output logic cmd_valid_in,
  output logic [5:0] cmd_gate_in,
  output logic [5:0] cmd_retry_in
);
  // idle levels: pins released, no command
  initial begin
    device_reset_in_n = 1'b1;
    global_enable_in_n = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_gate_in = 6'h00;
    cmd_retry_in = 6'h00;
  end
  // one command strobe, then the least gap before the next frame
  task automatic send(input logic [5:0] gate, input logic [5:0] retry);
    @(posedge ref_clk_in);
    #1;
    cmd_valid_in = 1'b1;
    cmd_gate_in = gate;
    cmd_retry_in = retry;
    @(posedge ref_clk_in);
    #1;
    cmd_valid_in = 1'b0;
    // stale data must not look valid once the strobe drops
    cmd_gate_in = ~gate;
    cmd_retry_in = ~retry;
    repeat (prec_pkg::XFER_GAP_CYC) @(posedge ref_clk_in);
  endtask : send
  // move the reset and enable pins just after an edge
  task automatic pins(input logic rst_n, input logic en_n);
    @(posedge ref_clk_in);
    #1;
    device_reset_in_n = rst_n;
    global_enable_in_n = en_n;
  endtask : pins
endmodule : prec_host_model

// ==== verif/tb_predriver_reset_enable_control.sv ====
`timescale 1ns/1ps
// bench for the reset and enable sequencer
module tb_predriver_reset_enable_control;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic dev_rst_n, en_n, cmd_valid;
  logic [5:0] cmd_gate, cmd_retry, gate, latched;
  logic [5:0] fault_det_in = 6'h00;
  logic oe, flag_n, port_en, timer_run, diag_en;
  int err_count = 0;
  int compares = 0;
  // 100 MHz clock
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  prec_host_model host (.ref_clk_in(ref_clk_in), .device_reset_in_n(dev_rst_n),
    .global_enable_in_n(en_n), .cmd_valid_in(cmd_valid), .cmd_gate_in(cmd_gate),
    .cmd_retry_in(cmd_retry));
  prec_seq dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .device_reset_in_n(dev_rst_n),
    .global_enable_in_n(en_n), .cmd_valid_in(cmd_valid), .cmd_gate_in(cmd_gate),
    .cmd_retry_in(cmd_retry), .fault_det_in(fault_det_in), .gate_drive_out(gate),
    .fault_flag_oe_out(oe), .fault_flag_out_n(flag_n), .port_enable_out(port_en),
    .timer_run_out(timer_run), .diag_enable_out(diag_en), .fault_latched_out(latched));
  // compare one value and report a mismatch
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // let synchroniser, sequencer and output flops settle
  task automatic settle();
    repeat (6) @(posedge ref_clk_in);
    #1;
  endtask : settle
  // report counts and verdict, then stop
  task automatic close_out();
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // defaults after power-on, then a command is accepted
  task automatic t_power_up();
    settle();
    chk(gate, prec_pkg::GATE_RST);
    chk(latched, prec_pkg::FAULT_RST);
    chk({5'h00, flag_n}, 6'h01);
    chk({5'h00, port_en}, 6'h01);
    host.send(6'h2A, 6'h00);
    settle();
    chk(gate, 6'h2A);
  endtask : t_power_up
  // external reset blocks everything, release restores defaults
  task automatic t_ext_reset();
    host.pins(1'b0, 1'b0);
    settle();
    chk({2'h0, gate == 6'h00, oe, port_en, timer_run}, 6'h08);
    chk(latched, 6'h00);
    host.pins(1'b1, 1'b0);
    settle();
    chk({4'h0, port_en, flag_n}, 6'h03);
    chk(gate, prec_pkg::GATE_RST);
  endtask : t_ext_reset
  // fault shuts a channel, enable high disables, enable low revives
  task automatic t_enable();
    host.send(6'h3F, 6'h00);
    settle();
    chk(gate, 6'h3F);
    @(posedge ref_clk_in);
    #1;
    fault_det_in = 6'h01;
    @(posedge ref_clk_in);
    #1;
    fault_det_in = 6'h00;
    settle();
    chk(latched, 6'h01);
    chk(gate, 6'h3E);
    chk({4'h0, oe, flag_n}, 6'h02);
    host.pins(1'b1, 1'b1);
    settle();
    chk(gate, 6'h00);
    chk({4'h0, diag_en, port_en}, 6'h01);
    chk(latched, 6'h01);
    host.pins(1'b1, 1'b0);
    settle();
    chk(gate, 6'h3F);
    chk({4'h0, diag_en, timer_run}, 6'h03);
  endtask : t_enable
  // auto-retry releases a fault-shut channel after the retry period
  task automatic t_retry();
    host.send(6'h3F, 6'h01);
    @(posedge ref_clk_in);
    #1;
    fault_det_in = 6'h01;
    @(posedge ref_clk_in);
    #1;
    fault_det_in = 6'h00;
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk(gate, 6'h3E);
    repeat (prec_pkg::RETRY_PERIOD - 16'h0003) @(posedge ref_clk_in);
    #1;
    chk(gate, 6'h3E);
    settle();
    chk(gate, 6'h3F);
  endtask : t_retry
  // supply drop in mid-run forces gates low and flag off at once
  task automatic t_supply_drop();
    @(posedge ref_clk_in);
    #1;
    rst_b_in = 1'b0;
    #1;
    chk(gate, 6'h00);
    chk({4'h0, oe, flag_n}, 6'h01);
    settle();
    rst_b_in = 1'b1;
    settle();
    chk(gate, prec_pkg::GATE_RST);
    chk(latched, prec_pkg::FAULT_RST);
  endtask : t_supply_drop
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk_in);
    #1;
    rst_b_in = 1'b1;
    t_power_up();
    t_ext_reset();
    t_enable();
    t_retry();
    t_supply_drop();
    close_out();
  end
  // watchdog against a hang
  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule : tb_predriver_reset_enable_control
